// ### rtl/asf_pkg.sv
// shared constants, types and helpers for the accelerometer sample buffer
package asf_pkg;

   ////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int ASF_DATA_W = 10;
   localparam int ASF_DEPTH  = 32;
   localparam int ASF_ADDR_W = 7;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [6:0] ASF_OFS_X_LOW  = 7'h28;
   localparam logic [6:0] ASF_OFS_X_HIGH = 7'h29;
   localparam logic [6:0] ASF_OFS_Y_LOW  = 7'h2A;
   localparam logic [6:0] ASF_OFS_Y_HIGH = 7'h2B;
   localparam logic [6:0] ASF_OFS_Z_LOW  = 7'h2C;
   localparam logic [6:0] ASF_OFS_Z_HIGH = 7'h2D;
   localparam logic [6:0] ASF_OFS_CTRL   = 7'h2E;
   localparam logic [6:0] ASF_OFS_STATUS = 7'h3E;
   localparam logic [6:0] ASF_OFS_ROUTE  = 7'h3F;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int ASF_CTRL_MODE_LSB = 6;
   localparam int ASF_CTRL_WTM_EN   = 5;
   localparam int ASF_CTRL_THR_MSB  = 4;
   localparam int ASF_RT_LINE1_LSB  = 0;
   localparam int ASF_RT_LINE2_LSB  = 3;

   ////////////////////////////////////////////////////////////////////////
   // reset values and the read value of unmapped offsets
   localparam logic [7:0] ASF_CTRL_RST  = 8'h00;
   localparam logic [7:0] ASF_ROUTE_RST = 8'h00;
   localparam logic [7:0] ASF_RDATA_RST = 8'h00;
   localparam logic [7:0] ASF_UNMAPPED  = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // policy codes in the control register mode field
   typedef enum logic [1:0] {
      ASF_MODE_BYPASS = 2'h0,
      ASF_MODE_FILL   = 2'h1,
      ASF_MODE_STREAM = 2'h2,
      ASF_MODE_TRIG   = 2'h3
   } asf_mode_t;

   // policy state, one-hot
   typedef enum logic [3:0] {
      ASF_ST_BYPASS  = 4'b0001,
      ASF_ST_FILL    = 4'b0010,
      ASF_ST_STREAM  = 4'b0100,
      ASF_ST_PRETRIG = 4'b1000
   } asf_state_t;

   // one x, y, z sample set
   typedef struct packed {
      logic [ASF_DATA_W-1:0] x;
      logic [ASF_DATA_W-1:0] y;
      logic [ASF_DATA_W-1:0] z;
   } asf_sample_t;

   // result byte: left-justified two's complement, zero stays 00h
   function automatic logic [7:0] asf_result_byte(
      input logic [ASF_DATA_W-1:0] d,
      input logic                  hi
   );
      logic [15:0] wide;
      wide = {d, 6'h00};
      return hi ? wide[15:8] : wide[7:0];
   endfunction

endpackage

// ### rtl/asf_sample_mem.sv
// storage array for buffered sample sets, one write port, async read
`timescale 1ns/1ns
module asf_sample_mem
   import asf_pkg::*;
#(
   parameter int WIDTH = 3 * ASF_DATA_W,
   parameter int DEPTH = ASF_DEPTH,
   parameter int PTR_W = $clog2(ASF_DEPTH)
) (
   // clock
   input  wire logic             clock,
   // write side
   input  wire logic             wrEn,
   input  wire logic [PTR_W-1:0] wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   // read side
   input  wire logic [PTR_W-1:0] rdAddr,
   output logic      [WIDTH-1:0] rdData
);

   // no reset: contents are only meaningful below the fill count
   logic [WIDTH-1:0] memArray [DEPTH];

   always_ff @(posedge clock) begin
      if (wrEn) begin
         memArray[wrAddr] <= wrData;
      end
   end

   assign rdData = memArray[rdAddr];

endmodule // asf_sample_mem

// ### rtl/asf_sample_fifo.sv
// three-channel accelerometer sample buffer with register port
`timescale 1ns/1ns
module asf_sample_fifo
   import asf_pkg::*;
#(
   parameter int DEPTH = ASF_DEPTH,
   parameter int PTR_W = $clog2(ASF_DEPTH)
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // sample input from the measurement chain
   input  wire logic                  sampleValid,
   input  wire asf_sample_t           sampleSet,
   input  wire logic                  triggerIn,
   // register port from the serial interface
   input  wire logic [ASF_ADDR_W-1:0] regAddr,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   input  wire logic [7:0]            regWdata,
   output logic      [7:0]            regRdata,
   output logic                       regRvalid,
   // event outputs
   output logic                       event_line_one,
   output logic                       event_line_two,
   output logic                       dataReady
);

   localparam int CNT_W = PTR_W + 1;
   localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0]       ctrlReg;
   logic [7:0]       routeReg;
   asf_state_t       stateReg;
   logic [PTR_W-1:0] wrPtrReg;
   logic [PTR_W-1:0] rdPtrReg;
   logic [CNT_W-1:0] countReg;
   asf_sample_t      resultReg;
   logic             overrunReg;

   ////////////////////////////////////////////////////////////////////////
   // decode
   logic        ctrlWrite;
   logic        routeWrite;
   logic        statusRead;
   logic        firstRead;
   asf_mode_t   newMode;
   logic        flushNow;
   logic        isFull;
   logic        isEmpty;
   logic        overwriteMode;
   logic        storing;
   logic        popReq;
   logic        overwrite;
   logic        push;
   logic        dropped;
   logic        advanceRd;
   logic        wtmLevel;
   logic [2:0]  eventFlags;
   asf_sample_t headSet;
   asf_sample_t srcSet;
   logic [7:0]  rdByte;
   logic [3*ASF_DATA_W-1:0] memRdData;

   assign ctrlWrite  = regWrite && (regAddr == ASF_OFS_CTRL);
   assign routeWrite = regWrite && (regAddr == ASF_OFS_ROUTE);
   assign statusRead = regRead && (regAddr == ASF_OFS_STATUS);
   assign firstRead  = regRead && (regAddr == ASF_OFS_X_LOW);
   assign newMode    = asf_mode_t'(regWdata[ASF_CTRL_MODE_LSB +: 2]);
   assign flushNow   = ctrlWrite && (newMode == ASF_MODE_BYPASS);
   assign isFull     = (countReg == FULL_COUNT);
   assign isEmpty    = (countReg == '0);
   assign headSet    = asf_sample_t'(memRdData);

   // only the stream phases may throw the oldest set away
   assign overwriteMode = (stateReg == ASF_ST_STREAM) ||
                          (stateReg == ASF_ST_PRETRIG);
   // bypass never writes the array
   assign storing   = sampleValid && (stateReg != ASF_ST_BYPASS) && !flushNow;
   // a read of x low pops the oldest set in buffered policies
   assign popReq    = firstRead && (stateReg != ASF_ST_BYPASS) && !isEmpty;
   assign overwrite = storing && isFull && !popReq && overwriteMode;
   // fill-and-stop refuses samples once full
   assign push      = storing && (!isFull || popReq || overwrite);
   assign dropped   = storing && !push;
   assign advanceRd = popReq || overwrite;

   assign wtmLevel  = countReg >= {1'b0, ctrlReg[ASF_CTRL_THR_MSB:0]};
   assign eventFlags = {isFull, isEmpty,
                        wtmLevel && ctrlReg[ASF_CTRL_WTM_EN]};

   ////////////////////////////////////////////////////////////////////////
   // storage, one word holds all three axes
   asf_sample_mem #(
      .WIDTH (3 * ASF_DATA_W),
      .DEPTH (DEPTH),
      .PTR_W (PTR_W)
   ) u_mem (
      .clock  (clock),
      .wrEn   (push),
      .wrAddr (wrPtrReg),
      .wrData (sampleSet),
      .rdAddr (rdPtrReg),
      .rdData (memRdData)
   );

   ////////////////////////////////////////////////////////////////////////
   // control and routing registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrlReg <= ASF_CTRL_RST;
      end else if (ctrlWrite) begin
         ctrlReg <= regWdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         routeReg <= ASF_ROUTE_RST;
      end else if (routeWrite) begin
         routeReg <= regWdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // policy state machine
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stateReg <= ASF_ST_BYPASS;
      end else if (ctrlWrite) begin
         case (newMode)
            ASF_MODE_BYPASS: stateReg <= ASF_ST_BYPASS;
            ASF_MODE_FILL:   stateReg <= ASF_ST_FILL;
            ASF_MODE_STREAM: stateReg <= ASF_ST_STREAM;
            ASF_MODE_TRIG:   stateReg <= ASF_ST_PRETRIG;
            default:         stateReg <= ASF_ST_BYPASS;
         endcase
      end else begin
         case (stateReg)
            ASF_ST_PRETRIG: begin
               // trigger turns the stream into fill-and-stop
               if (triggerIn) begin
                  stateReg <= ASF_ST_FILL;
               end
            end
            ASF_ST_BYPASS:  stateReg <= ASF_ST_BYPASS;
            ASF_ST_FILL:    stateReg <= ASF_ST_FILL;
            ASF_ST_STREAM:  stateReg <= ASF_ST_STREAM;
            default:        stateReg <= ASF_ST_BYPASS;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pointers and fill count
   // limitation: pointers wrap naturally, so DEPTH must be a power of two
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wrPtrReg <= '0;
      end else if (flushNow) begin
         wrPtrReg <= '0;
      end else if (push) begin
         wrPtrReg <= wrPtrReg + PTR_W'(1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdPtrReg <= '0;
      end else if (flushNow) begin
         rdPtrReg <= '0;
      end else if (advanceRd) begin
         rdPtrReg <= rdPtrReg + PTR_W'(1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         countReg <= '0;
      end else if (flushNow) begin
         countReg <= '0;
      end else if (push && !advanceRd) begin
         countReg <= countReg + CNT_W'(1);
      end else if (advanceRd && !push) begin
         countReg <= countReg - CNT_W'(1);
      end
   end

   // sticky note of a refused sample; a new drop beats the clearing read
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         overrunReg <= 1'b0;
      end else if (dropped) begin
         overrunReg <= 1'b1;
      end else if (statusRead) begin
         overrunReg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result latch
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         resultReg <= '0;
      end else if (stateReg == ASF_ST_BYPASS) begin
         // live sample sits in the single first location
         if (sampleValid) begin
            resultReg <= sampleSet;
         end
      end else if (popReq) begin
         resultReg <= headSet;
      end
   end

   // new set visible to host; a sample in the clearing cycle wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dataReady <= 1'b0;
      end else if (sampleValid) begin
         dataReady <= 1'b1;
      end else if (firstRead) begin
         dataReady <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data
   // the popping read returns the fresh head at once, so a burst from
   // x low to z high sees one coherent set
   assign srcSet = popReq ? headSet : resultReg;

   always_comb begin
      case (regAddr)
         ASF_OFS_X_LOW:  rdByte = asf_result_byte(srcSet.x, 1'b0);
         ASF_OFS_X_HIGH: rdByte = asf_result_byte(srcSet.x, 1'b1);
         ASF_OFS_Y_LOW:  rdByte = asf_result_byte(srcSet.y, 1'b0);
         ASF_OFS_Y_HIGH: rdByte = asf_result_byte(srcSet.y, 1'b1);
         ASF_OFS_Z_LOW:  rdByte = asf_result_byte(srcSet.z, 1'b0);
         ASF_OFS_Z_HIGH: rdByte = asf_result_byte(srcSet.z, 1'b1);
         ASF_OFS_CTRL:   rdByte = ctrlReg;
         ASF_OFS_STATUS: rdByte = {wtmLevel, overrunReg, countReg};
         ASF_OFS_ROUTE:  rdByte = routeReg;
         default:        rdByte = ASF_UNMAPPED;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= ASF_RDATA_RST;
      end else if (regRead) begin
         regRdata <= rdByte;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         regRvalid <= 1'b0;
      end else begin
         regRvalid <= regRead;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event lines, levels that follow the count one cycle late
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         event_line_one <= 1'b0;
      end else begin
         event_line_one <= |(eventFlags &
                             routeReg[ASF_RT_LINE1_LSB +: 3]);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         event_line_two <= 1'b0;
      end else begin
         event_line_two <= |(eventFlags &
                             routeReg[ASF_RT_LINE2_LSB +: 3]);
      end
   end

endmodule // asf_sample_fifo

// ### tb/asf_sample_fifo_monitor.sv
// concurrent checks on the sample buffer ports
`timescale 1ns/1ns
module asf_sample_fifo_monitor
   import asf_pkg::*;
(
   // clock and reset
   input wire logic                  clock,
   input wire logic                  rst_n,
   // sample side
   input wire logic                  sampleValid,
   input wire asf_sample_t           sampleSet,
   input wire logic                  triggerIn,
   // register port
   input wire logic [ASF_ADDR_W-1:0] regAddr,
   input wire logic                  regWrite,
   input wire logic                  regRead,
   input wire logic [7:0]            regWdata,
   input wire logic [7:0]            regRdata,
   input wire logic                  regRvalid,
   // events
   input wire logic                  event_line_one,
   input wire logic                  event_line_two,
   input wire logic                  dataReady
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   // shadows of the writable registers
   logic [7:0] ctlReg;
   logic [7:0] rtReg;
   logic       rdX;
   assign rdX = regRead && regAddr == ASF_OFS_X_LOW;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctlReg <= ASF_CTRL_RST;
         rtReg  <= ASF_ROUTE_RST;
      end else if (regWrite) begin
         if (regAddr == ASF_OFS_CTRL) ctlReg <= regWdata;
         if (regAddr == ASF_OFS_ROUTE) rtReg <= regWdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   AST_RVALID: assert property (regRead |=> regRvalid)
      else $error("read not answered");
   AST_NORVALID: assert property (!regRead |=> !regRvalid)
      else $error("answer without read");
   AST_RDHOLD: assert property (!regRead |=> $stable(regRdata))
      else $error("read data moved");
   AST_DRDYSET: assert property (sampleValid |=> dataReady)
      else $error("data ready missed");
   AST_DRDYHOLD: assert property (dataReady && !rdX |=> dataReady)
      else $error("data ready dropped");
   AST_DRDYCLR: assert property (rdX && !sampleValid |=> !dataReady)
      else $error("data ready not cleared");
   AST_CTLRB: assert property (regRead && !regWrite
      && regAddr == ASF_OFS_CTRL |=> regRdata == $past(ctlReg))
      else $error("control readback wrong");
   AST_BYPEMPTY: assert property (regRead && !regWrite
      && regAddr == ASF_OFS_STATUS && ctlReg[7:6] == 2'h0
      |=> regRdata[5:0] == 6'h00)
      else $error("bypass count not zero");
   AST_NOROUTE: assert property (rtReg == 8'h00
      && $past(rtReg) == 8'h00 |-> !event_line_one && !event_line_two)
      else $error("unrouted event line high");
   AST_UNMAP: assert property (regRead && regAddr < 7'h28
      |=> regRdata == ASF_UNMAPPED)
      else $error("unmapped read not zero");
   cover property (rdX ##1 regRvalid);
   cover property (triggerIn && ctlReg[7:6] == 2'h3);
   cover property ($rose(event_line_two));
endmodule // asf_sample_fifo_monitor

// ### tb/asf_host_model.sv
// host register master for the sample buffer
`timescale 1ns/1ns
module asf_host_model
   import asf_pkg::*;
(
   // clock
   input  wire logic                  clock,
   // register port
   output logic      [ASF_ADDR_W-1:0] regAddr,
   output logic                       regWrite,
   output logic                       regRead,
   output logic      [7:0]            regWdata,
   input  wire logic [7:0]            regRdata,
   input  wire logic                  regRvalid
);
   initial begin
      regAddr  = 7'h00;
      regWrite = 1'b0;
      regRead  = 1'b0;
      regWdata = 8'h00;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   // bounded wait so a silent design cannot hang the host
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      int n;
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (regRvalid !== 1'b1 && n < 4);
      // a missing answer reads as unknown so the caller's compare fails
      d = (regRvalid === 1'b1) ? regRdata : 8'hXX;
   endtask
endmodule // asf_host_model

// ### tb/tb_top.sv
// self-checking bench for the sample buffer
`timescale 1ns/1ns
module tb_top
   import asf_pkg::*;
;
   logic        clock, rst_n, sampleValid, triggerIn;
   asf_sample_t sampleSet;
   logic [6:0]  regAddr;
   logic        regWrite, regRead, regRvalid, lineOne, lineTwo, dataReady;
   logic [7:0]  regWdata, regRdata;
   int          nMismatch = 0;
   int          testsRun = 0;
   asf_sample_fifo i_asf_sample_fifo (.clock(clock), .rst_n(rst_n),
      .sampleValid(sampleValid), .sampleSet(sampleSet),
      .triggerIn(triggerIn), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .regRvalid(regRvalid), .event_line_one(lineOne),
      .event_line_two(lineTwo), .dataReady(dataReady));
   asf_host_model i_asf_host_model (.clock(clock), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
      .regRdata(regRdata), .regRvalid(regRvalid));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         nMismatch++;
      end
   endtask
   task automatic rdChk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_asf_host_model.rd(a, d);
      chk(d, exp);
   endtask
   task automatic cntChk(input logic [5:0] exp);
      logic [7:0] d;
      i_asf_host_model.rd(ASF_OFS_STATUS, d);
      chk({2'b00, d[5:0]}, {2'b00, exp});
   endtask
   // result bytes: high holds the top eight bits, sign included
   task automatic axisChk(input logic [6:0] a, input logic [9:0] v);
      rdChk(a, {v[1:0], 6'h00});
      rdChk(a + 7'h01, v[9:2]);
   endtask
   task automatic setChk(input logic [9:0] v);
      axisChk(ASF_OFS_X_LOW, v);
      axisChk(ASF_OFS_Y_LOW, v + 10'h155);
      axisChk(ASF_OFS_Z_LOW, ~v);
   endtask
   task automatic push(input logic [9:0] base, input int n);
      logic [9:0] v;
      for (int i = 0; i < n; i++) begin
         v = base + 10'(i);
         @(posedge clock);
         sampleValid <= 1'b1;
         sampleSet   <= '{v, v + 10'h155, ~v};
      end
      @(posedge clock);
      sampleValid <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic testReset;
      rdChk(ASF_OFS_CTRL, ASF_CTRL_RST);
      rdChk(ASF_OFS_ROUTE, ASF_ROUTE_RST);
      rdChk(7'h10, ASF_UNMAPPED);
      chk({6'h00, lineOne, dataReady}, 8'h00);
      $display("test reset done");
   endtask
   task automatic testFill;
      i_asf_host_model.wr(ASF_OFS_ROUTE, 8'h21);
      i_asf_host_model.wr(ASF_OFS_CTRL, 8'h64);
      push(10'h200, 3);
      chk({7'h00, lineOne}, 8'h00);
      push(10'h203, 1);
      chk({7'h00, lineOne}, 8'h01);
      push(10'h204, 29);
      chk({6'h00, lineOne, lineTwo}, 8'h03);
      rdChk(ASF_OFS_STATUS, 8'hE0);
      chk({7'h00, dataReady}, 8'h01);
      setChk(10'h200);
      chk({7'h00, lineTwo}, 8'h00);
      chk({7'h00, dataReady}, 8'h00);
      $display("test fill done");
   endtask
   task automatic testStream;
      i_asf_host_model.wr(ASF_OFS_CTRL, 8'h00);
      cntChk(6'h00);
      i_asf_host_model.wr(ASF_OFS_CTRL, 8'h80);
      push(10'h3F0, 34);
      cntChk(6'h20);
      setChk(10'h3F2);
      cntChk(6'h1F);
      $display("test stream done");
   endtask
   task automatic testTrig;
      i_asf_host_model.wr(ASF_OFS_CTRL, 8'h00);
      i_asf_host_model.wr(ASF_OFS_CTRL, 8'hC0);
      push(10'h050, 34);
      @(posedge clock);
      triggerIn <= 1'b1;
      @(posedge clock);
      triggerIn <= 1'b0;
      push(10'h0A0, 1);
      setChk(10'h052);
      $display("test trigger done");
   endtask
   task automatic testBypass;
      i_asf_host_model.wr(ASF_OFS_CTRL, 8'h00);
      i_asf_host_model.wr(ASF_OFS_ROUTE, 8'h02);
      push(10'h123, 1);
      chk({7'h00, lineOne}, 8'h01);
      setChk(10'h123);
      cntChk(6'h00);
      $display("test bypass done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic printVerdict;
      $display("checks %0d mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge clock);
      nMismatch++;
      printVerdict();
   end
   initial begin
      rst_n       = 1'b0;
      sampleValid = 1'b0;
      sampleSet   = '0;
      triggerIn   = 1'b0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      testReset();
      testFill();
      testStream();
      testTrig();
      testBypass();
      printVerdict();
   end
endmodule // tb_top

bind asf_sample_fifo asf_sample_fifo_monitor i_asf_sample_fifo_monitor (
   .clock(clock), .rst_n(rst_n), .sampleValid(sampleValid),
   .sampleSet(sampleSet), .triggerIn(triggerIn), .regAddr(regAddr),
   .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
   .regRdata(regRdata), .regRvalid(regRvalid),
   .event_line_one(event_line_one), .event_line_two(event_line_two),
   .dataReady(dataReady));
